// ==== inc/ssd_defs.svh ====
// Offsets, field positions, reset values and counts of the switch decoder
`ifndef SSD_DEFS_SVH
`define SSD_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSD_OFS_STATUS 4'h0
`define SSD_OFS_DECODE 4'h4
`define SSD_OFS_NET_ADDR 4'h8
`define SSD_OFS_NET_RATE 4'hc
`define SSD_OFS_SWITCHES 5'h10
`define SSD_ADDR_W 5
`define SSD_ADDR_SPAN 5'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSD_ST_DONE 0
`define SSD_ST_INVALID 1
`define SSD_ST_MISMATCH 2
`define SSD_ST_HOLD 3
`define SSD_ST_SRC 4
`define SSD_ST_CLEAR 5
`define SSD_DEC_ADDR 0
`define SSD_DEC_RATE 8
`define SSD_DEC_VALVE 16
`define SSD_DEC_IBUS 20
`define SSD_DEC_DIAG 24

// ----------------------------------------------------------------
// Switch positions inside the banks (bit 0 is position 1)
// ----------------------------------------------------------------
`define SSD_B2_DIAG0 0
`define SSD_B2_DIAG1 1
`define SSD_B2_HOLD 2
`define SSD_B2_SRC 3
`define SSD_B2_MEM 4

// ----------------------------------------------------------------
// Decode limits and reset values
// ----------------------------------------------------------------
`define SSD_DIGIT_MAX 4'h9
`define SSD_ADDR_PGM_MIN 8'h40
`define SSD_ADDR_TEN 8'h0a
`define SSD_RATE_PGM_MIN 4'h3
`define SSD_RST_ADDR 6'h00
`define SSD_RST_VALVE 3'h4
`define SSD_DIAG_B0 4'h0
`define SSD_DIAG_B1 4'h4
`define SSD_DIAG_B2 4'h6
`define SSD_DIAG_B3 4'hc
`define SSD_SETTLE_CYCLES 3'h4

`endif

// ==== inc/ssd_pkg.sv ====
// Types shared by the switch decoder files
package ssd_pkg;

    // Fieldbus data rate codes
    typedef enum logic [1:0] {
        SSD_RATE_125K = 2'h0,
        SSD_RATE_250K = 2'h1,
        SSD_RATE_500K = 2'h2
    } ssd_rate_e;

    // Internal bus speed codes
    typedef enum logic [1:0] {
        SSD_IBUS_1M = 2'h0,
        SSD_IBUS_500K = 2'h1,
        SSD_IBUS_250K = 2'h2,
        SSD_IBUS_125K = 2'h3
    } ssd_ibus_e;

    // Power-up sequence states, one-hot
    typedef enum logic [2:0] {
        SSD_SETTLE = 3'h1,
        SSD_LATCH = 3'h2,
        SSD_RUN = 3'h4
    } ssd_state_e;

endpackage

// ==== rtl/ssd_sync.sv ====
// Two-flop synchroniser for the switch pins
`timescale 1ns/1ns
`default_nettype none

module ssd_sync #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pin side and clock side
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);

    // First stage feeds only the second stage
    logic [WIDTH-1:0] meta_reg;

    // Both stages clear to the all-OFF position
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_reg <= '0;
            syncOut <= '0;
        end else begin
            meta_reg <= pinIn;
            syncOut <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/ssd_cfg_memory.sv ====
// Manifold configuration reference store and power-up comparison
`timescale 1ns/1ns
`default_nettype none

module ssd_cfg_memory #(
    parameter int CFG_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Power-up capture request
    input wire logic capture,
    input wire logic compareMode,
    input wire logic [CFG_W-1:0] presentConfig,
    // Result
    output logic mismatch
);

    // Reference survives reset, like a non-volatile store
    logic [CFG_W-1:0] reference_reg;

    // Store the reference when the memory switch is OFF
    always_ff @(posedge clk) begin
        if (capture && !compareMode) begin
            reference_reg <= presentConfig;
        end
    end

    // Compare once at power-up, flag stays until next reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mismatch <= 1'b0;
        end else if (capture && compareMode) begin
            mismatch <= (reference_reg != presentConfig);
        end
    end

endmodule
`default_nettype wire

// ==== rtl/ssd_switch_decoder.sv ====
// Setting switch decoder with AXI4-Lite register access
// ----------------------------------------------------------------
// How it works
// - Sample switches at power-up, ignore later changes
// - All-OFF and zero digits give default configuration
// - Address is tens times ten plus units
// - Rate digit 0/1/2 gives 125/250/500 kbps
// - Programmed rate digit takes network-written rate
// - Source selector picks switches or network controller
// - Bank one 1-2 select valve output size
// - Bank one 3-4 select internal bus speed
// - Diagnostic mode adds 0/4/6/12 input bytes
// - Hold/clear decides outputs on error or idle
// - Memory switch ON compares stored configuration
// - Memory switch OFF stores present configuration
// - Bank two positions 6-8 are ignored
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "ssd_defs.svh"

module ssd_switch_decoder
    import ssd_pkg::*;
#(
    parameter int CFG_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Setting switch pins
    input wire logic [3:0] tensDigitSwitch,
    input wire logic [3:0] unitsDigitSwitch,
    input wire logic [3:0] rateDigitSwitch,
    input wire logic [3:0] switchBankOne,
    input wire logic [7:0] switchBankTwo,
    // Manifold and fieldbus status from the I/O path
    input wire logic [CFG_W-1:0] manifoldConfig,
    input wire logic commError,
    input wire logic busIdle,
    // Decoded configuration
    output logic [5:0] nodeAddress,
    output logic [1:0] netRate,
    output logic [2:0] valveBytes,
    output logic [1:0] internalBusRate,
    output logic [3:0] diagBytes,
    output logic holdOutputs,
    output logic outputsClear,
    output logic configInvalid,
    output logic configMismatch,
    output logic decodeDone,
    // AXI4-Lite write channels
    input wire logic [`SSD_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [`SSD_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    // ------------------------------------------------------------
    // Switch synchronisation and power-up sequence
    // ------------------------------------------------------------
    logic [23:0] pinBundle; // All switch pins in one vector
    logic [23:0] syncBundle; // Pins after two flops
    ssd_state_e state_reg; // Power-up sequence state
    ssd_state_e state_next;
    logic [2:0] settle_reg; // Synchroniser flush counter
    logic [3:0] tens_reg; // Latched tens digit
    logic [3:0] units_reg; // Latched units digit
    logic [3:0] rateDigit_reg; // Latched rate digit
    logic [3:0] bankOne_reg; // Latched bank one
    logic [4:0] bankTwo_reg; // Latched bank two, positions 1-5
    logic capture_reg; // Configuration memory strobe
    logic [5:0] netAddr_reg; // Address written over the network
    logic [1:0] netRate_reg; // Rate written over the network

    assign pinBundle = {tensDigitSwitch, unitsDigitSwitch,
                        rateDigitSwitch, switchBankOne, switchBankTwo};

    ssd_sync #(
        .WIDTH(24)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn(pinBundle),
        .syncOut(syncBundle)
    );

    // Sequence: flush synchroniser, latch once, then run
    always_comb begin
        case (state_reg)
            SSD_SETTLE: begin
                state_next = (settle_reg == `SSD_SETTLE_CYCLES) ?
                             SSD_LATCH : SSD_SETTLE;
            end
            SSD_LATCH: begin
                state_next = SSD_RUN;
            end
            SSD_RUN: begin
                state_next = SSD_RUN;
            end
            default: begin
                state_next = SSD_SETTLE;
            end
        endcase
    end

    // State and settle counter
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= SSD_SETTLE;
            settle_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            if (state_reg == SSD_SETTLE) begin
                settle_reg <= settle_reg + 3'h1;
            end
        end
    end

    // Latch switches once; reset values are the OFF positions
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tens_reg <= 4'h0;
            units_reg <= 4'h0;
            rateDigit_reg <= 4'h0;
            bankOne_reg <= 4'h0;
            bankTwo_reg <= 5'h00;
        end else if (state_reg == SSD_LATCH) begin
            tens_reg <= syncBundle[23:20];
            units_reg <= syncBundle[19:16];
            rateDigit_reg <= syncBundle[15:12];
            bankOne_reg <= syncBundle[11:8];
            bankTwo_reg <= syncBundle[4:0];
        end
    end

    // One strobe to the configuration memory after the latch
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            capture_reg <= 1'b0;
        end else begin
            capture_reg <= (state_reg == SSD_LATCH);
        end
    end

    ssd_cfg_memory #(
        .CFG_W(CFG_W)
    ) u_cfg (
        .clk(clk),
        .reset_n(reset_n),
        .capture(capture_reg),
        .compareMode(bankTwo_reg[`SSD_B2_MEM]),
        .presentConfig(manifoldConfig),
        .mismatch(configMismatch)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic running = (state_reg == SSD_RUN);
    wire logic srcNetwork = bankTwo_reg[`SSD_B2_SRC];
    wire logic [7:0] addrSum = 8'(tens_reg * `SSD_ADDR_TEN)
                               + {4'h0, units_reg};
    wire logic digitBad = (tens_reg > `SSD_DIGIT_MAX)
                          || (units_reg > `SSD_DIGIT_MAX);
    wire logic rateBad = (rateDigit_reg > `SSD_DIGIT_MAX);
    wire logic addrPgm = (addrSum >= `SSD_ADDR_PGM_MIN) && !digitBad;
    wire logic ratePgm = (rateDigit_reg >= `SSD_RATE_PGM_MIN)
                         && !rateBad;
    wire logic invalidNext = ((addrPgm || ratePgm) && !srcNetwork)
                             || digitBad || rateBad;
    wire logic useNetAddr = srcNetwork && addrPgm;
    wire logic useNetRate = srcNetwork && ratePgm;
    wire logic [5:0] addrNext = invalidNext ? `SSD_RST_ADDR :
                                useNetAddr ? netAddr_reg :
                                addrSum[5:0];
    wire logic [1:0] rateNext = invalidNext ? SSD_RATE_125K :
                                useNetRate ? netRate_reg :
                                rateDigit_reg[1:0];
    wire logic [2:0] valveNext = `SSD_RST_VALVE
                                 - {1'b0, bankOne_reg[0],
                                    bankOne_reg[1]};
    wire logic [1:0] ibusNext = {bankOne_reg[2],
                                 bankOne_reg[3]};
    wire logic [1:0] diagMode = {bankTwo_reg[`SSD_B2_DIAG1],
                                 bankTwo_reg[`SSD_B2_DIAG0]};
    wire logic [3:0] diagNext = (diagMode == 2'h0) ? `SSD_DIAG_B0 :
                                (diagMode == 2'h1) ? `SSD_DIAG_B1 :
                                (diagMode == 2'h2) ? `SSD_DIAG_B2 :
                                `SSD_DIAG_B3;
    wire logic holdNext = bankTwo_reg[`SSD_B2_HOLD];

    // Decoded outputs follow the latched switches and network values
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            nodeAddress <= `SSD_RST_ADDR;
            netRate <= SSD_RATE_125K;
            valveBytes <= `SSD_RST_VALVE;
            internalBusRate <= SSD_IBUS_1M;
            diagBytes <= `SSD_DIAG_B0;
            holdOutputs <= 1'b0;
            configInvalid <= 1'b0;
            decodeDone <= 1'b0;
        end else if (running) begin
            nodeAddress <= addrNext;
            netRate <= rateNext;
            valveBytes <= valveNext;
            internalBusRate <= ibusNext;
            diagBytes <= diagNext;
            holdOutputs <= holdNext;
            configInvalid <= invalidNext;
            decodeDone <= 1'b1;
        end
    end

    // Clear outputs on fieldbus error or idle unless hold is chosen
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            outputsClear <= 1'b0;
        end else begin
            outputsClear <= running && !holdNext
                            && (commError || busIdle);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    wire logic wrGo = awvalid && wvalid && !awready && !bvalid;
    wire logic rdGo = arvalid && !arready && !rvalid;
    wire logic [3:0] wrOfs = awaddr[3:0];
    wire logic [3:0] rdOfs = araddr[3:0];
    wire logic wrMapped = (awaddr < `SSD_ADDR_SPAN) && !awaddr[1]
                          && !awaddr[0];
    wire logic rdMapped = (araddr < `SSD_ADDR_SPAN) && !araddr[1]
                          && !araddr[0];
    wire logic [31:0] statusWord = {26'h0, outputsClear,
                                    srcNetwork, holdOutputs,
                                    configMismatch, configInvalid,
                                    decodeDone};
    wire logic [31:0] decodeWord = {4'h0, diagBytes, 2'h0,
                                    internalBusRate, 1'b0, valveBytes,
                                    6'h00, netRate, 2'h0, nodeAddress};
    wire logic [31:0] switchWord = {11'h000, bankTwo_reg,
                                    bankOne_reg, rateDigit_reg,
                                    units_reg, tens_reg};
    wire logic [31:0] rdWord =
        !rdMapped ? 32'h0 :
        araddr[4] ? switchWord :
        (rdOfs == `SSD_OFS_STATUS) ? statusWord :
        (rdOfs == `SSD_OFS_DECODE) ? decodeWord :
        (rdOfs == `SSD_OFS_NET_ADDR) ? {26'h0, netAddr_reg} :
        {30'h0, netRate_reg};

    // Write: take address and data together, answer next cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            awready <= wrGo;
            wready <= wrGo;
            if (awready) begin
                bvalid <= 1'b1;
                bresp <= wrMapped ? 2'h0 : 2'h2;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Network-programmed address and rate, written by the controller
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            netAddr_reg <= 6'h00;
            netRate_reg <= SSD_RATE_125K;
        end else if (wrGo && wrMapped && !awaddr[4] && wstrb[0]) begin
            if (wrOfs == `SSD_OFS_NET_ADDR) begin
                netAddr_reg <= wdata[5:0];
            end else if (wrOfs == `SSD_OFS_NET_RATE) begin
                netRate_reg <= wdata[1:0];
            end
        end
    end

    // Read: accept address, answer data next cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'h0;
        end else begin
            arready <= rdGo;
            if (rdGo) begin
                rdata <= rdWord;
                rresp <= rdMapped ? 2'h0 : 2'h2;
            end
            if (arready) begin
                rvalid <= 1'b1;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_RUN_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)
        running |=> running && $stable(tens_reg)
        && $stable(bankOne_reg))
        else $error("switch latch changed after power-up");

    AST_DEFAULTS: assert property (@(posedge clk) disable iff (!reset_n)
        !decodeDone |-> nodeAddress == 6'h00 && valveBytes == 3'h4
        && diagBytes == 4'h0 && netRate == 2'h0)
        else $error("outputs not at defaults before decode");

    AST_ADDR_SUM: assert property (@(posedge clk) disable iff (!reset_n)
        running && !invalidNext && !useNetAddr
        |=> nodeAddress == 6'(tens_reg * 4'ha + units_reg))
        else $error("node address not tens*10+units");

    AST_NET_RATE: assert property (@(posedge clk) disable iff (!reset_n)
        running && useNetRate && !invalidNext
        |=> netRate == $past(netRate_reg))
        else $error("programmed rate not taken from network");

    AST_VALVE_SIZE: assert property (@(posedge clk) disable iff (!reset_n)
        running && bankOne_reg[1:0] == 2'h3 |=> valveBytes == 3'h1)
        else $error("both valve switches ON must give one byte");

    AST_IBUS: assert property (@(posedge clk) disable iff (!reset_n)
        running && bankOne_reg[3:2] == 2'h1 |=> internalBusRate == 2'h2)
        else $error("position 3 ON must give 250 kbps");

    AST_DIAG: assert property (@(posedge clk) disable iff (!reset_n)
        running && diagMode == 2'h2 |=> diagBytes == 4'h6)
        else $error("diagnostic mode 2 must add six bytes");

    AST_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
        running && holdNext |=> !outputsClear)
        else $error("outputs cleared while hold is selected");

    AST_INVALID: assert property (@(posedge clk) disable iff (!reset_n)
        configInvalid |-> nodeAddress == 6'h00 && netRate == 2'h0)
        else $error("invalid setting did not fall back to defaults");

    AST_MISMATCH: assert property (@(posedge clk) disable iff (!reset_n)
        running && !capture_reg |=> $stable(configMismatch))
        else $error("mismatch flag changed outside power-up check");

endmodule
`default_nettype wire

// ==== tb/ssd_io_partner.sv ====
// Model of the fieldbus protocol and manifold I/O side of the decoder
`timescale 1ns/1ns
`default_nettype none

module ssd_io_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Requests from the bench
    input wire logic errReq,
    input wire logic idleReq,
    input wire logic [31:0] cfgReq,
    // Toward the decoder
    output logic [31:0] manifoldConfig,
    output logic commError,
    output logic busIdle
);
    // Status moves on the clock, as the protocol logic would present it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            commError <= 1'b0;
            busIdle <= 1'b0;
        end else begin
            commError <= errReq;
            busIdle <= idleReq;
        end
        // Fitted modules stay visible through reset
        manifoldConfig <= cfgReq;
    end
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the setting switch decoder
`timescale 1ns/1ns
`default_nettype none
`include "ssd_defs.svh"
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin failCount++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module testbench;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk = 1'b0, reset_n = 1'b0, errReq = 1'b0, idleReq = 1'b0;
    logic [3:0] tensDigitSwitch = 4'h0, unitsDigitSwitch = 4'h0;
    logic [3:0] rateDigitSwitch = 4'h0, switchBankOne = 4'h0;
    logic [7:0] switchBankTwo = 8'h00;
    logic [31:0] cfgReq = 32'h0, manifoldConfig, wdata = 32'h0, rdata;
    logic commError, busIdle, holdOutputs, outputsClear, configInvalid;
    logic configMismatch, decodeDone, awready, wready, bvalid, arready;
    logic rvalid;
    logic [5:0] nodeAddress;
    logic [1:0] netRate, internalBusRate, bresp, rresp;
    logic [2:0] valveBytes;
    logic [3:0] diagBytes, wstrb = 4'hf;
    logic [`SSD_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    int failCount = 0, nTests = 0;

    // Free-running 100 MHz clock
    initial forever #5 clk = ~clk;

    ssd_switch_decoder i_dut (.clk, .reset_n, .tensDigitSwitch,
        .unitsDigitSwitch, .rateDigitSwitch, .switchBankOne, .switchBankTwo,
        .manifoldConfig, .commError, .busIdle, .nodeAddress, .netRate,
        .valveBytes, .internalBusRate, .diagBytes, .holdOutputs,
        .outputsClear, .configInvalid, .configMismatch, .decodeDone,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready);
    ssd_io_partner i_partner (.clk, .reset_n, .errReq, .idleReq, .cfgReq,
        .manifoldConfig, .commError, .busIdle);

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Verdict and end of run
    task automatic testDone();
        if (failCount == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // A bounded wait ran out
    task automatic hang();
        failCount++;
        $display("[FAIL] handshake exp answer got timeout");
        testDone();
    endtask
    // Write one word and compare the response code
    task automatic wrChk(input logic [4:0] a, input logic [31:0] d,
                         input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 40) hang();
        `CHK("bresp", er, bresp)
        bready <= 1'b0;
    endtask
    // Read one word and compare data and response code
    task automatic rdChk(input logic [4:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 40) hang();
        `CHK("rdata", ed, rdata)
        `CHK("rresp", er, rresp)
        rready <= 1'b0;
    endtask
    // Set the switches, cycle power and wait for the decode
    task automatic powerUp(input logic [3:0] t, u, rt, b1,
                           input logic [7:0] b2);
        int n;
        @(posedge clk);
        reset_n <= 1'b0;
        tensDigitSwitch <= t;
        unitsDigitSwitch <= u;
        rateDigitSwitch <= rt;
        switchBankOne <= b1;
        switchBankTwo <= b2;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (decodeDone === 1'b1) break;
        end
        if (n == 40) hang();
    endtask
    // Compare address, rate, valve, bus speed, diagnostic and invalid fields
    task automatic chkDec(input logic [5:0] a, input logic [1:0] r,
        input logic [2:0] v, input logic [1:0] ib, input logic [3:0] dg,
        input logic inv);
        `CHK("nodeAddress", a, nodeAddress)
        `CHK("netRate", r, netRate)
        `CHK("valveBytes", v, valveBytes)
        `CHK("internalBusRate", ib, internalBusRate)
        `CHK("diagBytes", dg, diagBytes)
        `CHK("configInvalid", inv, configInvalid)
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // All switches off, status words and an address just past the end of the map
    task automatic testDefaults();
        powerUp(4'h0, 4'h0, 4'h0, 4'h0, 8'h00);
        chkDec(6'd0, 2'h0, 3'h4, 2'h0, 4'h0, 1'b0);
        `CHK("holdOutputs", 1'b0, holdOutputs)
        rdChk(`SSD_OFS_STATUS, 32'h1, 2'h0);
        rdChk(`SSD_OFS_DECODE, 32'h00040000, 2'h0);
        rdChk(`SSD_ADDR_SPAN, 32'h0, 2'h2);
        wrChk(`SSD_ADDR_SPAN, 32'h1, 2'h2);
    endtask
    // Field encodings, bounds and changes after the latch
    task automatic testTable();
        powerUp(4'h6, 4'h3, 4'h2, 4'b0001, 8'h05);
        chkDec(6'd63, 2'h2, 3'h2, 2'h0, 4'h4, 1'b0);
        rdChk(`SSD_OFS_DECODE, 32'h0402023f, 2'h0);
        wrChk(`SSD_OFS_DECODE, 32'hffffffff, 2'h0);
        rdChk(`SSD_OFS_SWITCHES, 32'h00051236, 2'h0);
        @(posedge clk);
        tensDigitSwitch <= 4'h1;
        rateDigitSwitch <= 4'h0;
        switchBankOne <= 4'hf;
        switchBankTwo <= 8'h00;
        repeat (12) @(posedge clk);
        chkDec(6'd63, 2'h2, 3'h2, 2'h0, 4'h4, 1'b0);
        `CHK("holdOutputs", 1'b1, holdOutputs)
        powerUp(4'h1, 4'h2, 4'h1, 4'b0110, 8'he2);
        chkDec(6'd12, 2'h1, 3'h3, 2'h2, 4'h6, 1'b0);
        powerUp(4'h0, 4'h5, 4'h0, 4'b1011, 8'h03);
        chkDec(6'd5, 2'h0, 3'h1, 2'h1, 4'hc, 1'b0);
        powerUp(4'h9, 4'h9, 4'h0, 4'b1100, 8'h00);
        chkDec(6'd0, 2'h0, 3'h4, 2'h3, 4'h0, 1'b1);
        powerUp(4'h2, 4'h0, 4'h3, 4'h0, 8'h00);
        chkDec(6'd0, 2'h0, 3'h4, 2'h0, 4'h0, 1'b1);
        powerUp(4'h1, 4'h0, 4'h2, 4'h0, 8'h08);
        chkDec(6'd10, 2'h2, 3'h4, 2'h0, 4'h0, 1'b0);
    endtask
    // Source selector on, address and rate written over the network
    task automatic testNetwork();
        powerUp(4'h6, 4'h4, 4'h7, 4'h0, 8'h08);
        wrChk(`SSD_OFS_NET_ADDR, 32'd37, 2'h0);
        wrChk(`SSD_OFS_NET_RATE, 32'h2, 2'h0);
        repeat (3) @(posedge clk);
        `CHK("nodeAddress", 6'd37, nodeAddress)
        `CHK("netRate", 2'h2, netRate)
        `CHK("configInvalid", 1'b0, configInvalid)
        rdChk(`SSD_OFS_NET_ADDR, 32'd37, 2'h0);
    endtask
    // Output clearing on error and idle, and the hold setting
    task automatic testHold();
        powerUp(4'h0, 4'h1, 4'h0, 4'h0, 8'h00);
        errReq <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("outputsClear", 1'b1, outputsClear)
        errReq <= 1'b0;
        idleReq <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("outputsClear", 1'b1, outputsClear)
        idleReq <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("outputsClear", 1'b0, outputsClear)
        powerUp(4'h0, 4'h1, 4'h0, 4'h0, 8'h04);
        errReq <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("outputsClear", 1'b0, outputsClear)
        errReq <= 1'b0;
    endtask
    // Store the manifold, then compare against same and changed ones
    task automatic testMemory();
        cfgReq <= 32'h00a5c3e1;
        powerUp(4'h0, 4'h2, 4'h0, 4'h0, 8'h00);
        powerUp(4'h0, 4'h2, 4'h0, 4'h0, 8'h10);
        repeat (2) @(posedge clk);
        `CHK("configMismatch", 1'b0, configMismatch)
        cfgReq <= 32'h00a5c3e3;
        powerUp(4'h0, 4'h2, 4'h0, 4'h0, 8'h10);
        repeat (2) @(posedge clk);
        `CHK("configMismatch", 1'b1, configMismatch)
    endtask

    // Main sequence
    initial begin
        testDefaults();
        testTable();
        testNetwork();
        testHold();
        testMemory();
        testDone();
    end
endmodule

`default_nettype wire
